// ---- ossc_pkg.sv ----
// Constants for the output resync and standby control block.
// Assumes a single sample clock domain; all users import the whole package.
//
// How it works
// R1: Resync clears filter and serial clock counters.
// R2: Resync leaves clock synthesizer dividers alone.
// R3: Resync also resets the sigma-delta modulator.
// R4: Clean samples start twelve samples after release.
// R5: Host holds resync low half a clock.
// R6: During resync bit clock high, frame low.
// R7: Bit clock resumes within one-two periods.
// R8: Frame sync restart delay fixed, repeatable.
// R9: Host checks alignment by watching frame syncs.
// R10: Power-up: standby register reads all ones.
// R11: Clearing a bit wakes that block.
// R12: All blocks standby also stops master reference.
// R13: Standby bit map: seven down to zero.
// R14: Clock buffer off needs PLL and converter.
// R15: Converter standby halts filter clock, freezes outputs.
// R16: Gain DAC standby three-states both gain outputs.
// R17: Data shifts on rising clock after frame pulse.
// R18: Bit clock is sample clock over divisor.
// R19: Resync input passes two-stage synchronizer first.
package ossc_pkg;

   // ==========================================================
   // Standby register
   // ==========================================================
   localparam logic [7:0] OSSC_BLOCK_STANDBY_CONTROL_RESET = 8'hFF;      // All blocks asleep at power-up
   localparam logic [7:0] OSSC_BLOCK_STANDBY_CONTROL_BLOCKS = 8'hFD;     // Every bit but the unused one
   localparam int OSSC_BIT_BIAS_REF = 7;                // Bias reference
   localparam int OSSC_BIT_MIXER_PLL = 6;               // Mixer PLL, pump three-state
   localparam int OSSC_BIT_OSC = 5;                     // Clock oscillator
   localparam int OSSC_BIT_SAMPLE_PLL = 4;              // Sample clock PLL
   localparam int OSSC_BIT_GAIN_DAC = 3;                // Gain control DAC
   localparam int OSSC_BIT_FRONT_END = 2;               // LNA and mixer
   localparam int OSSC_BIT_CONVERTER = 0;               // Converter

   // ==========================================================
   // Timing
   // ==========================================================
   localparam logic [3:0] OSSC_CLEAN_SAMPLES = 4'hC;    // Samples disturbed by a resync
   localparam logic [3:0] OSSC_MIN_DIVISOR = 4'h2;      // Smallest divisor a register can toggle at
   localparam logic OSSC_RESYNC_IDLE = 1'b1;            // Resync pin level when idle

   // ==========================================================
   // Serial frame states
   // ==========================================================
   typedef enum logic [1:0] {
      OSSC_IDLE,
      OSSC_FSYNC,
      OSSC_SHIFT
   } ossc_frame_t;

endpackage

// ---- ossc_sync2.sv ----
// Two flip-flop level synchronizer for the asynchronous resync pin.
// Assumes the pin is slow against the clock; the first stage feeds only the second.
module ossc_sync2 import ossc_pkg::*; (
   // Clocking
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // Level
   input wire logic d_in,
   output logic q_out
);

   // ==========================================================
   // Stages
   // ==========================================================
   logic meta_r;   // First stage, may go metastable
   logic meta_nxt; // Next first stage
   logic sync_r;   // Second stage, safe to use
   logic sync_nxt; // Next second stage

   // Next values; frozen while the enable is low
   always_comb begin
      meta_nxt = ce ? d_in : meta_r;
      sync_nxt = ce ? meta_r : sync_r;
   end

   // Registers rest at the idle level so reset is not seen as a resync
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_r <= OSSC_RESYNC_IDLE;
         sync_r <= OSSC_RESYNC_IDLE;
      end else begin
         meta_r <= meta_nxt; // R19
         sync_r <= sync_nxt; // R19
      end
   end

   assign q_out = sync_r;

endmodule // ossc_sync2

// ---- ossc_ctrl.sv ----
// Resync, serial output timing and standby control of the digitizer back end.
// Assumes MCLK is the sample clock; the standby register is written by the control port.
module ossc_ctrl import ossc_pkg::*; #(
   parameter int DECIM_W = 12,        // Width of the decimation count
   parameter int FRAME_BITS = 32,     // Bits per output frame
   parameter int BITCNT_W = 7         // Width of the frame bit counter
) (
   // Clock and reset
   input wire logic MCLK,
   input wire logic RST,
   input wire logic CE,
   // Resync pin, asynchronous, active low
   input wire logic RESYNC_REQUEST_N,
   // Output timing setup
   input wire logic [3:0] OUTPUT_RATE_DIVISOR,
   input wire logic [DECIM_W-1:0] DECIM_FACTOR,
   input wire logic [FRAME_BITS-1:0] SAMPLE_DATA,
   // Standby register port
   input wire logic BLOCK_STANDBY_CONTROL_WR_EN,
   input wire logic [7:0] BLOCK_STANDBY_CONTROL_WR_DATA,
   output logic [7:0] BLOCK_STANDBY_CONTROL,
   // Serial output
   output logic SERIAL_BIT_CLOCK_OUT,
   output logic FRAME_SYNC_OUT,
   output logic SERIAL_DATA_OUT,
   output logic SAMPLE_TAKEN,
   output logic DATA_CLEAN,
   // Converter control
   output logic MODULATOR_RESET,
   output logic FILTER_CLOCK_EN,
   // Power control
   output logic BIAS_REF_STANDBY,
   output logic MIXER_PLL_STANDBY,
   output logic MIXER_PUMP_OUT_OE_N,
   output logic SAMPLE_OSCILLATOR_STANDBY,
   output logic SAMPLE_PLL_STANDBY,
   output logic SAMPLE_PUMP_OUT_OE_N,
   output logic GAIN_DAC_STANDBY,
   output logic GAIN_CTRL_POS_OE_N,
   output logic GAIN_CTRL_NEG_OE_N,
   output logic FRONT_END_STANDBY,
   output logic CONVERTER_STANDBY,
   output logic COMMON_MODE_OUT_OE_N,
   output logic CLOCK_BUFFER_OFF,
   output logic MASTER_REF_STANDBY
);

   // ==========================================================
   // Resync pin synchronizer
   // ==========================================================
   logic resync_n_s; // Synchronized resync level
   logic resync;     // Resync held, active high

   ossc_sync2 u_sync (
      .clk(MCLK),
      .rst(RST),
      .ce(CE),
      .d_in(RESYNC_REQUEST_N),
      .q_out(resync_n_s)
   );

   assign resync = ~resync_n_s; // R19

   // ==========================================================
   // Standby register
   // ==========================================================
   logic [7:0] block_standby_control_r;   // Standby bits, 1 keeps a block down
   logic [7:0] block_standby_control_nxt; // Next standby bits

   // Software write; a zero wakes the matching block
   always_comb begin
      block_standby_control_nxt = block_standby_control_r;
      if (CE && BLOCK_STANDBY_CONTROL_WR_EN) begin
         block_standby_control_nxt = BLOCK_STANDBY_CONTROL_WR_DATA; // R11
      end
   end

   // Comes up with everything asleep
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         block_standby_control_r <= OSSC_BLOCK_STANDBY_CONTROL_RESET; // R10
      end else begin
         block_standby_control_r <= block_standby_control_nxt;
      end
   end

   // Decoded power controls straight from register bits
   always_comb begin
      BLOCK_STANDBY_CONTROL = block_standby_control_r;
      BIAS_REF_STANDBY = block_standby_control_r[OSSC_BIT_BIAS_REF]; // R13
      MIXER_PLL_STANDBY = block_standby_control_r[OSSC_BIT_MIXER_PLL]; // R13
      MIXER_PUMP_OUT_OE_N = block_standby_control_r[OSSC_BIT_MIXER_PLL]; // R13
      SAMPLE_OSCILLATOR_STANDBY = block_standby_control_r[OSSC_BIT_OSC]; // R13
      SAMPLE_PLL_STANDBY = block_standby_control_r[OSSC_BIT_SAMPLE_PLL]; // R13
      SAMPLE_PUMP_OUT_OE_N = block_standby_control_r[OSSC_BIT_SAMPLE_PLL]; // R13
      GAIN_DAC_STANDBY = block_standby_control_r[OSSC_BIT_GAIN_DAC]; // R16
      GAIN_CTRL_POS_OE_N = block_standby_control_r[OSSC_BIT_GAIN_DAC]; // R16
      GAIN_CTRL_NEG_OE_N = block_standby_control_r[OSSC_BIT_GAIN_DAC]; // R16
      FRONT_END_STANDBY = block_standby_control_r[OSSC_BIT_FRONT_END]; // R13
      CONVERTER_STANDBY = block_standby_control_r[OSSC_BIT_CONVERTER]; // R13
      COMMON_MODE_OUT_OE_N = block_standby_control_r[OSSC_BIT_CONVERTER]; // R13
      // Buffer feeds both PLL and converter, so both must sleep
      CLOCK_BUFFER_OFF = block_standby_control_r[OSSC_BIT_SAMPLE_PLL] & block_standby_control_r[OSSC_BIT_CONVERTER]; // R14
      // Unused bit ignored when judging all blocks asleep
      MASTER_REF_STANDBY = ((block_standby_control_r & OSSC_BLOCK_STANDBY_CONTROL_BLOCKS) == OSSC_BLOCK_STANDBY_CONTROL_BLOCKS); // R12
   end

   // ==========================================================
   // Timing counters
   // ==========================================================
   // Synthesizer dividers live elsewhere and never see the resync, so
   // devices sharing a sample clock keep their phase relation. // R2
   logic run;                       // Logic advances this cycle
   logic [3:0] ord;                 // Effective bit clock divisor
   logic [3:0] half;                // High phase length
   logic [3:0] div_r;               // Bit clock divider
   logic [3:0] div_nxt;
   logic clk_r;                     // Bit clock level
   logic clk_nxt;
   logic rise;                      // Bit clock rises next edge
   logic [DECIM_W-1:0] dec_r;       // Decimation counter
   logic [DECIM_W-1:0] dec_nxt;
   logic tick;                      // One output sample produced
   logic [3:0] clean_r;             // Samples since release, saturating
   logic [3:0] clean_nxt;

   // Converter standby stops the filter clock and freezes the serial, sample-taken and clean outputs
   assign run = CE & ~block_standby_control_r[OSSC_BIT_CONVERTER]; // R15
   assign FILTER_CLOCK_EN = run;
   // Divisor below two cannot be toggled by a register at this rate
   assign ord = (OUTPUT_RATE_DIVISOR < OSSC_MIN_DIVISOR) ? OSSC_MIN_DIVISOR
                                                          : OUTPUT_RATE_DIVISOR;
   assign half = ord >> 1;
   assign rise = (div_r == ord - 4'h1);
   assign tick = (dec_r == DECIM_FACTOR - {{(DECIM_W-1){1'b0}}, 1'b1});

   // Next counter values
   always_comb begin
      div_nxt = div_r;
      clk_nxt = clk_r;
      dec_nxt = dec_r;
      clean_nxt = clean_r;
      if (run) begin
         if (resync) begin
            // Held cleared for the whole low time
            div_nxt = 4'h0; // R1
            dec_nxt = '0; // R1
            clk_nxt = 1'b1; // R6
            clean_nxt = 4'h0; // R4
         end else begin
            // Bit clock is the sample clock over the divisor
            div_nxt = rise ? 4'h0 : div_r + 4'h1; // R18
            // High phase first, so a wrap of the divider is a rising edge
            clk_nxt = (div_nxt < half) ? 1'b1 : 1'b0; // R7
            dec_nxt = tick ? '0 : dec_r + {{(DECIM_W-1){1'b0}}, 1'b1};
            if (tick && clean_r != OSSC_CLEAN_SAMPLES) begin
               clean_nxt = clean_r + 4'h1; // R4
            end
         end
      end
   end

   // Register counters
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         div_r <= 4'h0;
         clk_r <= 1'b1;
         dec_r <= '0;
         clean_r <= 4'h0;
      end else begin
         div_r <= div_nxt;
         clk_r <= clk_nxt;
         dec_r <= dec_nxt;
         clean_r <= clean_nxt;
      end
   end

   // ==========================================================
   // Frame sequencer
   // ==========================================================
   ossc_frame_t st_r;               // Frame state
   ossc_frame_t st_nxt;
   logic pend_r;                    // Sample waiting for a frame
   logic pend_nxt;
   logic fs_r;                      // Frame sync level
   logic fs_nxt;
   logic dout_r;                    // Serial data bit
   logic dout_nxt;
   logic [FRAME_BITS-1:0] sh_r;     // Shift register
   logic [FRAME_BITS-1:0] sh_nxt;
   logic [BITCNT_W-1:0] bit_r;      // Bits sent in this frame
   logic [BITCNT_W-1:0] bit_nxt;
   logic take_r;                    // Sample latched pulse
   logic take_nxt;

   // Frame timing is a pure function of the counters, hence repeatable
   always_comb begin
      st_nxt = st_r;
      pend_nxt = pend_r;
      fs_nxt = fs_r;
      dout_nxt = dout_r;
      sh_nxt = sh_r;
      bit_nxt = bit_r;
      take_nxt = take_r;
      if (run) begin
         // Pulse lasts one running cycle; frozen like the rest otherwise
         take_nxt = 1'b0;
         if (resync) begin
            // Whole port restarts from a clean state
            st_nxt = OSSC_IDLE; // R1
            pend_nxt = 1'b0; // R1
            fs_nxt = 1'b0; // R6
            dout_nxt = 1'b0;
            bit_nxt = '0;
         end else begin
            // A new sample wins over the frame start clearing it
            if (rise && st_r == OSSC_IDLE) begin
               pend_nxt = 1'b0;
            end
            if (tick) begin
               pend_nxt = 1'b1; // R8
            end
            if (rise) begin
               case (st_r)
                  OSSC_IDLE: begin
                     if (pend_r) begin
                        // One bit clock of frame sync ahead of data
                        st_nxt = OSSC_FSYNC; // R17
                        fs_nxt = 1'b1; // R17
                        sh_nxt = SAMPLE_DATA;
                        take_nxt = 1'b1;
                     end
                  end
                  OSSC_FSYNC: begin
                     st_nxt = OSSC_SHIFT;
                     fs_nxt = 1'b0; // R17
                     dout_nxt = sh_r[FRAME_BITS-1]; // R17
                     sh_nxt = {sh_r[FRAME_BITS-2:0], 1'b0};
                     bit_nxt = {{(BITCNT_W-1){1'b0}}, 1'b1};
                  end
                  OSSC_SHIFT: begin
                     if (bit_r == BITCNT_W'(FRAME_BITS)) begin
                        st_nxt = OSSC_IDLE;
                        dout_nxt = 1'b0;
                        bit_nxt = '0;
                     end else begin
                        // Data moves with the rising bit clock
                        dout_nxt = sh_r[FRAME_BITS-1]; // R17
                        sh_nxt = {sh_r[FRAME_BITS-2:0], 1'b0};
                        bit_nxt = bit_r + {{(BITCNT_W-1){1'b0}}, 1'b1};
                     end
                  end
                  default: begin
                     st_nxt = OSSC_IDLE;
                  end
               endcase
            end
         end
      end
   end

   // Register frame state
   always_ff @(posedge MCLK or posedge RST) begin
      if (RST) begin
         st_r <= OSSC_IDLE;
         pend_r <= 1'b0;
         fs_r <= 1'b0;
         dout_r <= 1'b0;
         sh_r <= '0;
         bit_r <= '0;
         take_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         pend_r <= pend_nxt;
         fs_r <= fs_nxt;
         dout_r <= dout_nxt;
         sh_r <= sh_nxt;
         bit_r <= bit_nxt;
         take_r <= take_nxt;
      end
   end

   // ==========================================================
   // Outputs
   // ==========================================================
   assign SERIAL_BIT_CLOCK_OUT = clk_r;
   assign FRAME_SYNC_OUT = fs_r;
   assign SERIAL_DATA_OUT = dout_r;
   assign SAMPLE_TAKEN = take_r;
   assign DATA_CLEAN = (clean_r == OSSC_CLEAN_SAMPLES); // R4
   // Modulator held in reset for the synchronized low time
   assign MODULATOR_RESET = resync; // R3

endmodule // ossc_ctrl

// ---- ossc_ctrl_properties.sv ----
// Concurrent checks on the resync and standby control ports.
// Assumes it is bound into ossc_ctrl: one clock, reset active high.
module ossc_chk import ossc_pkg::*; (
   // Clock, reset and inputs
   input wire logic MCLK,
   input wire logic RST,
   input wire logic CE,
   input wire logic RESYNC_REQUEST_N,
   input wire logic BLOCK_STANDBY_CONTROL_WR_EN,
   input wire logic [7:0] BLOCK_STANDBY_CONTROL_WR_DATA,
   // Serial and converter outputs
   input wire logic [7:0] BLOCK_STANDBY_CONTROL,
   input wire logic SERIAL_BIT_CLOCK_OUT,
   input wire logic FRAME_SYNC_OUT,
   input wire logic SERIAL_DATA_OUT,
   input wire logic DATA_CLEAN,
   input wire logic MODULATOR_RESET,
   input wire logic FILTER_CLOCK_EN,
   // Power outputs
   input wire logic BIAS_REF_STANDBY,
   input wire logic MIXER_PLL_STANDBY,
   input wire logic SAMPLE_OSCILLATOR_STANDBY,
   input wire logic SAMPLE_PLL_STANDBY,
   input wire logic GAIN_DAC_STANDBY,
   input wire logic GAIN_CTRL_POS_OE_N,
   input wire logic GAIN_CTRL_NEG_OE_N,
   input wire logic FRONT_END_STANDBY,
   input wire logic CONVERTER_STANDBY,
   input wire logic CLOCK_BUFFER_OFF,
   input wire logic MASTER_REF_STANDBY
);
   // ==========================================================
   // Setup
   // ==========================================================
   wire logic [7:0] s = BLOCK_STANDBY_CONTROL; // Readback alias
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (RST);
   // ==========================================================
   // Standby register
   // ==========================================================
   a_reg_write: assert property (CE && BLOCK_STANDBY_CONTROL_WR_EN |=> s == $past(BLOCK_STANDBY_CONTROL_WR_DATA))
      else $error("standby write not taken");
   a_reg_hold: assert property (!(CE && BLOCK_STANDBY_CONTROL_WR_EN) |=> $stable(s))
      else $error("standby changed without write");
   a_bit_map: assert property ({BIAS_REF_STANDBY, MIXER_PLL_STANDBY, SAMPLE_OSCILLATOR_STANDBY,
      SAMPLE_PLL_STANDBY, GAIN_DAC_STANDBY, FRONT_END_STANDBY, CONVERTER_STANDBY} == {s[7:2], s[0]})
      else $error("standby bit map wrong");
   a_gain_three_state: assert property ({GAIN_CTRL_POS_OE_N, GAIN_CTRL_NEG_OE_N} == {2{s[3]}})
      else $error("gain outputs not three-stated");
   a_clkbuf_off: assert property (CLOCK_BUFFER_OFF == (s[4] && s[0]))
      else $error("clock buffer decode wrong");
   a_master_ref: assert property (MASTER_REF_STANDBY == ((s & OSSC_BLOCK_STANDBY_CONTROL_BLOCKS) == OSSC_BLOCK_STANDBY_CONTROL_BLOCKS))
      else $error("master reference decode wrong");
   a_conv_freeze: assert property (CONVERTER_STANDBY |-> !FILTER_CLOCK_EN ##1
      $stable({SERIAL_BIT_CLOCK_OUT, FRAME_SYNC_OUT, SERIAL_DATA_OUT}))
      else $error("outputs moved in converter standby");
   // ==========================================================
   // Resync and serial timing
   // ==========================================================
   a_resync_take: assert property ((!RESYNC_REQUEST_N && CE && !CONVERTER_STANDBY)[*3] |=>
      MODULATOR_RESET)
      else $error("resync not taken after synchronizer");
   a_resync_free: assert property ((RESYNC_REQUEST_N && CE && !CONVERTER_STANDBY)[*3] |=>
      !MODULATOR_RESET)
      else $error("modulator reset not released");
   a_resync_hold: assert property (MODULATOR_RESET && FILTER_CLOCK_EN |=> SERIAL_BIT_CLOCK_OUT
      && !FRAME_SYNC_OUT && !DATA_CLEAN)
      else $error("serial pins not parked during resync");
   a_clk_resume: assert property ($fell(MODULATOR_RESET) |-> ##[1:32] $fell(SERIAL_BIT_CLOCK_OUT))
      else $error("bit clock did not resume");
   a_fs_edge: assert property ($rose(FRAME_SYNC_OUT) |-> $rose(SERIAL_BIT_CLOCK_OUT))
      else $error("frame sync not on bit clock rise");
   // Main scenarios reached
   c_release: cover property ($fell(MODULATOR_RESET));
   c_clean: cover property ($rose(DATA_CLEAN));
   c_frame: cover property ($rose(FRAME_SYNC_OUT));
endmodule // ossc_chk

bind ossc_ctrl ossc_chk u_chk (
   .MCLK, .RST, .CE, .RESYNC_REQUEST_N, .BLOCK_STANDBY_CONTROL_WR_EN, .BLOCK_STANDBY_CONTROL_WR_DATA, .BLOCK_STANDBY_CONTROL,
   .SERIAL_BIT_CLOCK_OUT, .FRAME_SYNC_OUT, .SERIAL_DATA_OUT, .DATA_CLEAN, .MODULATOR_RESET,
   .FILTER_CLOCK_EN, .BIAS_REF_STANDBY, .MIXER_PLL_STANDBY, .SAMPLE_OSCILLATOR_STANDBY,
   .SAMPLE_PLL_STANDBY, .GAIN_DAC_STANDBY, .GAIN_CTRL_POS_OE_N, .GAIN_CTRL_NEG_OE_N,
   .FRONT_END_STANDBY, .CONVERTER_STANDBY, .CLOCK_BUFFER_OFF, .MASTER_REF_STANDBY
);

// ---- ossc_dsp_model.sv ----
// Receiving serial port model: collects 32-bit frames after each frame sync.
// Assumes the bit clock is sampled on the system clock; data is taken on its fall.
module ossc_dsp_model import ossc_pkg::*; (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Serial pins
   input wire logic bit_clk,
   input wire logic frame_sync,
   input wire logic data_in,
   // Received frames
   output logic [31:0] word_r,
   output int frames_r
);
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_d_r; // Bit clock one cycle back
   logic armed_r; // Frame under way
   int cnt_r; // Bits taken so far
   logic [31:0] sh_r; // Shift register
   // Falling bit clock is mid-bit, away from the data change
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         {clk_d_r, armed_r, cnt_r, sh_r, word_r, frames_r} <= '0;
      end else begin
         clk_d_r <= bit_clk;
         if (clk_d_r && !bit_clk) begin
            if (frame_sync) begin
               armed_r <= 1'b1;
               cnt_r <= 0;
            end else if (armed_r) begin
               sh_r <= {sh_r[30:0], data_in};
               cnt_r <= cnt_r + 1;
               if (cnt_r == 31) begin
                  word_r <= {sh_r[30:0], data_in};
                  frames_r <= frames_r + 1;
                  armed_r <= 1'b0;
               end
            end
         end
      end
   end
endmodule // ossc_dsp_model

// ---- ossc_ctrl_tb.sv ----
// Self-checking bench for the resync and standby control block.
// Assumes a 20 MHz sample clock and the receiving port model beside the design.
module ossc_ctrl_tb import ossc_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int DEC = 200; // Decimation, above frame length times divisor
   logic mclk, rst, ce, rsn, wen, sbc, fs, sdo, cln, mrst, fce, bias, mix, mixoe, sosc;
   logic spll, spoe, gain, gpos, gneg, fe, conv, cmoe, cbuf, mref, stk;
   logic [3:0] ord;
   logic [7:0] wdat, block_standby_control;
   logic [31:0] sdat, word;
   logic [7:0] tbl [8] = '{8'hFD, 8'hFC, 8'h11, 8'h10, 8'h01, 8'h08, 8'h40, 8'h00};
   int error_cnt, checks, cyc, frames;
   // ==========================================================
   // Design, port model, clock
   // ==========================================================
   ossc_ctrl DUT (.MCLK(mclk), .RST(rst), .CE(ce), .RESYNC_REQUEST_N(rsn),
      .OUTPUT_RATE_DIVISOR(ord), .DECIM_FACTOR(12'(DEC)), .SAMPLE_DATA(sdat),
      .BLOCK_STANDBY_CONTROL_WR_EN(wen), .BLOCK_STANDBY_CONTROL_WR_DATA(wdat), .BLOCK_STANDBY_CONTROL(block_standby_control),
      .SERIAL_BIT_CLOCK_OUT(sbc), .FRAME_SYNC_OUT(fs), .SERIAL_DATA_OUT(sdo), .SAMPLE_TAKEN(stk),
      .DATA_CLEAN(cln), .MODULATOR_RESET(mrst), .FILTER_CLOCK_EN(fce), .BIAS_REF_STANDBY(bias),
      .MIXER_PLL_STANDBY(mix), .MIXER_PUMP_OUT_OE_N(mixoe), .SAMPLE_OSCILLATOR_STANDBY(sosc),
      .SAMPLE_PLL_STANDBY(spll), .SAMPLE_PUMP_OUT_OE_N(spoe), .GAIN_DAC_STANDBY(gain),
      .GAIN_CTRL_POS_OE_N(gpos), .GAIN_CTRL_NEG_OE_N(gneg), .FRONT_END_STANDBY(fe),
      .CONVERTER_STANDBY(conv), .COMMON_MODE_OUT_OE_N(cmoe), .CLOCK_BUFFER_OFF(cbuf),
      .MASTER_REF_STANDBY(mref));
   ossc_dsp_model u_dsp (.clk(mclk), .rst(rst), .bit_clk(sbc), .frame_sync(fs),
      .data_in(sdo), .word_r(word), .frames_r(frames));
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   always @(posedge mclk) cyc <= cyc + 1; // Cycle count for timing
   // ==========================================================
   // Tasks
   // ==========================================================
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         $display("wrong value %s expected %h seen %h", nm, e, g);
         error_cnt++;
      end
   endtask
   // One-cycle write strobe; readback settles at the taking edge
   task automatic wr(input logic [7:0] v);
      @(posedge mclk);
      wen <= 1'b1;
      wdat <= v;
      @(posedge mclk);
      wen <= 1'b0;
      #1;
   endtask
   // Write a value and compare every decoded power output
   task automatic stb(input logic [7:0] v);
      wr(v);
      chk("standby", v, block_standby_control);
      chk("map", {v[7:2], v[0]}, {bias, mix, sosc, spll, gain, fe, conv});
      chk("pump oe", {v[6], v[4], v[0]}, {mixoe, spoe, cmoe});
      chk("gain oe", {2{v[3]}}, {gpos, gneg});
      chk("clk buf", v[4] & v[0], cbuf);
      chk("master", (v & 8'hFD) == 8'hFD, mref);
   endtask
   // Pulse resync, return cycles from release to first frame sync
   task automatic rsync(output int dly);
      int t;
      @(posedge mclk);
      rsn <= 1'b0;
      repeat (6) @(posedge mclk);
      #1;
      chk("parked", 3'b101, {sbc, fs, mrst});
      chk("clean low", 1'b0, cln);
      @(posedge mclk);
      rsn <= 1'b1;
      t = cyc;
      @(negedge sbc);
      #1;
      chk("resume", 1'b1, cyc - t <= 2 * ord + 3);
      @(posedge fs);
      #1;
      chk("taken", 1'b1, stk);
      dly = cyc - t;
      repeat (10 * DEC) @(posedge mclk);
      chk("clean early", 1'b0, cln);
      repeat (3 * DEC) if (cln !== 1'b1) @(posedge mclk);
      chk("clean", 1'b1, cln);
   endtask
   task automatic end_of_test();
      $display("checks %0d error_cnt %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // ==========================================================
   // Tests
   // ==========================================================
   initial begin
      int d1, d2, n, t;
      logic [2:0] pins;
      {error_cnt, checks} = '0;
      {ce, rsn, rst, ord, sdat, wen, wdat} = {3'b111, 4'h5, 32'hA5C30F96, 1'b0, 8'h00};
      repeat (12) @(posedge mclk);
      rst <= 1'b0;
      #1;
      chk("reset", {8'hFF, 3'b101}, {block_standby_control, sbc, fs, mref});
      foreach (tbl[i]) stb(tbl[i]);
      @(posedge mclk);
      ce <= 1'b0;
      wr(8'hFF);
      chk("refused", 8'h00, block_standby_control);
      @(posedge mclk);
      ce <= 1'b1;
      n = frames;
      repeat (4 * DEC) if (frames < n + 2) @(posedge mclk);
      chk("frames", 1'b1, frames >= n + 2);
      chk("word", sdat, word);
      foreach (tbl[i]) if (i < 2) begin
         ord <= i ? 4'h5 : 4'h0;
         repeat (2) @(posedge sbc);
         t = cyc;
         @(posedge sbc);
         chk("bit period", i ? 5 : 2, cyc - t);
      end
      rsync(d1);
      rsync(d2);
      chk("fs delay", 1'b1, d1 >= DEC && d1 == d2);
      wr(8'h01);
      pins = {sbc, fs, sdo};
      repeat (40) @(posedge mclk);
      #1;
      chk("frozen", {pins, 1'b0}, {sbc, fs, sdo, fce});
      end_of_test();
   end
   // Watchdog far beyond the expected run of some 5500 cycles
   initial begin
      repeat (30000) @(posedge mclk);
      error_cnt++;
      end_of_test();
   end
endmodule // ossc_ctrl_tb
